// ===== pkg/cst_pkg.sv
package cst_pkg;

    // counter geometry
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int DIV_W = 11;
    localparam int FS_DIV_W = 3;

    // prescaler taps, as powers of two of the system clock
    localparam int TAP_DIV11 = 11;
    localparam int TAP_DIV7 = 7;
    localparam int TAP_DIV5 = 5;
    localparam int TAP_DIV3 = 3;
    localparam int TAP_DIV1 = 1;

    // reset and limit values
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'h0000;
    localparam logic [CNT_W-1:0] DUTY_RST = 16'h0000;

    typedef enum logic [1:0] {
        MODE_TIMER = 2'h0,
        MODE_EVENT = 2'h1,
        MODE_PWM = 2'h3
    } cst_mode_t;

    typedef enum logic [2:0] {
        SRC_DIV11 = 3'h0,
        SRC_DIV7 = 3'h1,
        SRC_DIV5 = 3'h2,
        SRC_DIV3 = 3'h3,
        SRC_FS = 3'h4,
        SRC_FC_DIV2 = 3'h5,
        SRC_FC = 3'h6,
        SRC_EXT = 3'h7
    } cst_src_t;

    typedef enum logic {
        ST_STOP = 1'b0,
        ST_RUN = 1'b1
    } cst_state_t;

    // upper timer control byte as seen by the block
    typedef struct packed {
        logic init;
        cst_mode_t mode;
        cst_src_t src;
        logic run;
    } cst_ctrl_t;

    // one byte write into a 16-bit compare register
    typedef struct packed {
        logic wr;
        logic hi;
        logic [BYTE_W-1:0] data;
    } cst_bwr_t;

    localparam cst_ctrl_t CTRL_RST = '{init: 1'b0, mode: MODE_TIMER, src: SRC_DIV11, run: 1'b0};

    // merge one written byte into a compare word
    function automatic logic [CNT_W-1:0] byte_merge(input logic [CNT_W-1:0] word,
                                                    input cst_bwr_t w);
        logic [CNT_W-1:0] r;
        r = word;
        if (w.wr) begin
            if (w.hi) begin
                r[CNT_W-1:BYTE_W] = w.data;
            end else begin
                r[BYTE_W-1:0] = w.data;
            end
        end
        return r;
    endfunction

endpackage

// ===== src/cst_prescale.sv
`timescale 1ns/1ps
module cst_prescale import cst_pkg::*; #(
    parameter int DIV_WIDTH = DIV_W
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire cst_src_t src_in,
    input wire logic low_speed_sel_in,
    input wire logic slow_state_in,
    input wire logic lf_tick_in,
    output logic tick_out
);

    logic [DIV_WIDTH-1:0] div_q, div_d;
    logic [FS_DIV_W-1:0] fsdiv_q, fsdiv_d;
    logic tick_d;
    logic fs8;

    // true once every 2^k system clocks
    function automatic logic tap(input logic [DIV_WIDTH-1:0] d, input int k);
        logic t;
        t = 1'b1;
        for (int i = 0; i < k; i++) begin
            t = t & d[i];
        end
        return t;
    endfunction

    // free divider; fast taps die in slow states since the fast clock is gone
    always_comb begin
        div_d = DIV_WIDTH'(div_q + 1'b1);
        fsdiv_d = lf_tick_in ? FS_DIV_W'(fsdiv_q + 1'b1) : fsdiv_q;
        fs8 = lf_tick_in && (&fsdiv_q);
        unique case (src_in)
            SRC_DIV11: tick_d = (low_speed_sel_in || slow_state_in) ? fs8 :
                                tap(div_q, TAP_DIV11);
            SRC_DIV7: tick_d = !slow_state_in && tap(div_q, TAP_DIV7);
            SRC_DIV5: tick_d = !slow_state_in && tap(div_q, TAP_DIV5);
            SRC_DIV3: tick_d = !slow_state_in && tap(div_q, TAP_DIV3);
            SRC_FS: tick_d = lf_tick_in;
            SRC_FC_DIV2: tick_d = !slow_state_in && tap(div_q, TAP_DIV1);
            SRC_FC: tick_d = !slow_state_in;
            SRC_EXT: tick_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            div_q <= '0;
            fsdiv_q <= '0;
            tick_out <= 1'b0;
        end else begin
            div_q <= div_d;
            fsdiv_q <= fsdiv_d;
            tick_out <= tick_d;
        end
    end

    property p_slow_gate;
        @(posedge clk_in) disable iff (srst_in)
        slow_state_in && (src_in inside {SRC_DIV7, SRC_DIV5, SRC_DIV3, SRC_FC_DIV2, SRC_FC})
        |=> !tick_out;
    endproperty
    a_slow_gate: assert property (p_slow_gate)
        else $error("fast tap ticked in slow state");

    property p_fs_follow;
        @(posedge clk_in) disable iff (srst_in)
        (src_in == SRC_FS) |=> (tick_out == $past(lf_tick_in));
    endproperty
    a_fs_follow: assert property (p_fs_follow)
        else $error("low clock source tick mismatch");

endmodule

// ===== src/cst_duty_buf.sv
`timescale 1ns/1ps
module cst_duty_buf import cst_pkg::*; #(
    parameter int WIDTH = CNT_W
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire cst_bwr_t wr_in,
    input wire logic stopped_in,
    input wire logic load_in,
    output logic [WIDTH-1:0] active_out
);

    logic [WIDTH-1:0] buf_q, buf_d;
    logic [WIDTH-1:0] active_q, active_d;

    // writes land in the buffer; stopped writes pass straight through
    always_comb begin
        buf_d = byte_merge(buf_q, wr_in);
        active_d = active_q;
        if (load_in || (stopped_in && wr_in.wr)) begin
            active_d = buf_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            buf_q <= DUTY_RST;
            active_q <= DUTY_RST;
        end else begin
            buf_q <= buf_d;
            active_q <= active_d;
        end
    end

    // reads see the active copy, never the pending buffer
    assign active_out = active_q;

    property p_run_hold;
        @(posedge clk_in) disable iff (srst_in)
        !stopped_in && !load_in |=> $stable(active_q);
    endproperty
    a_run_hold: assert property (p_run_hold)
        else $error("active duty changed between matches");

    property p_load_moves;
        @(posedge clk_in) disable iff (srst_in)
        load_in && !wr_in.wr |=> (active_q == $past(buf_q));
    endproperty
    a_load_moves: assert property (p_load_moves)
        else $error("buffer not transferred on match");

endmodule

// ===== src/cst_timer.sv
`timescale 1ns/1ps
// Contract
// - interval mode joins both byte counters into one 16-bit counter on prescaled ticks.
// - with run set, count equal to period raises match, clears, keeps counting.
// - period has no buffer in timer and event modes; avoid changes while running.
// - interval clock is one of four fast taps, or low clock/8 when slow.
// - event mode advances the counter on each falling edge of the count input.
// - event mode match raises match, clears, resumes on the next falling edge.
// - PWM mode gives 16-bit duty from internal ticks or the count input.
// - duty match toggles the flop; overflow toggles again, clears and raises match.
// - output flop loads its level from the init bit; reset clears it.
// - the PWM pin always shows the inverse of the output flop.
// - running duty writes are buffered until match; stopped writes apply at once.
// - duty reads return the active value, not the pending buffered one.
// - stopping holds the pin level; init bit takes effect only once stopped.
// - PWM source adds low clock, fast clock/2 and fast clock; slow limits choices.
module cst_timer import cst_pkg::*; (
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic CTRL_WR_IN,
    input wire cst_ctrl_t CTRL_IN,
    input wire logic LOW_SPEED_SEL_IN,
    input wire logic SLOW_STATE_IN,
    input wire logic LF_TICK_IN,
    input wire logic EXT_COUNT_IN,
    input wire cst_bwr_t PERIOD_WR_IN,
    input wire cst_bwr_t DUTY_WR_IN,
    output logic [CNT_W-1:0] COUNT_OUT,
    output logic [CNT_W-1:0] PERIOD_RD_OUT,
    output logic [CNT_W-1:0] DUTY_RD_OUT,
    output logic MATCH_IRQ_OUT,
    output logic PWM_PIN_OUT,
    output logic OUTPUT_FLOP_OUT,
    output logic RUNNING_OUT
);

    cst_ctrl_t ctrl_q, ctrl_d;
    cst_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] cnt_inc;
    logic [CNT_W-1:0] period_q, period_d;
    logic [CNT_W-1:0] duty_act;
    logic flop_q, flop_d;
    logic pin_q, pin_d;
    logic irq_q, irq_d;
    logic ext_prev_q, ext_prev_d;
    logic pre_tick;
    logic ext_fall;
    logic step;
    logic running;
    logic duty_load;

    // byte counters chained: low byte carry feeds the high byte
    function automatic logic [CNT_W-1:0] cascade_inc(input logic [CNT_W-1:0] v);
        logic [BYTE_W:0] lo;
        logic [BYTE_W-1:0] hi;
        lo = {1'b0, v[BYTE_W-1:0]} + {{BYTE_W{1'b0}}, 1'b1};
        hi = v[CNT_W-1:BYTE_W] + {{(BYTE_W-1){1'b0}}, lo[BYTE_W]};
        return {hi, lo[BYTE_W-1:0]};
    endfunction

    // interval mode only knows the four divided sources
    function automatic logic timer_src_ok(input cst_src_t s);
        return s inside {SRC_DIV11, SRC_DIV7, SRC_DIV5, SRC_DIV3};
    endfunction

    cst_prescale #(
        .DIV_WIDTH(DIV_W)
    ) u_prescale (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .src_in(ctrl_q.src),
        .low_speed_sel_in(LOW_SPEED_SEL_IN),
        .slow_state_in(SLOW_STATE_IN),
        .lf_tick_in(LF_TICK_IN),
        .tick_out(pre_tick)
    );

    cst_duty_buf #(
        .WIDTH(CNT_W)
    ) u_duty (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .wr_in(DUTY_WR_IN),
        .stopped_in(!running),
        .load_in(duty_load),
        .active_out(duty_act)
    );

    // control byte and run state
    always_comb begin
        ctrl_d = CTRL_WR_IN ? CTRL_IN : ctrl_q;
        state_d = state_q;
        unique case (state_q)
            ST_STOP: begin
                if (CTRL_WR_IN && CTRL_IN.run) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (CTRL_WR_IN && !CTRL_IN.run) begin
                    state_d = ST_STOP;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            ctrl_q <= CTRL_RST;
            state_q <= ST_STOP;
        end else begin
            ctrl_q <= ctrl_d;
            state_q <= state_d;
        end
    end

    assign running = (state_q == ST_RUN);

    // period compare: no buffer, a byte write is live next cycle
    always_comb begin
        period_d = byte_merge(period_q, PERIOD_WR_IN);
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            period_q <= PERIOD_RST;
        end else begin
            period_q <= period_d;
        end
    end

    // count step selection; inputs are synchronous so one stage finds the edge
    always_comb begin
        ext_prev_d = EXT_COUNT_IN;
        ext_fall = ext_prev_q && !EXT_COUNT_IN;
        unique case (ctrl_q.mode)
            MODE_TIMER: step = pre_tick && timer_src_ok(ctrl_q.src);
            MODE_EVENT: step = ext_fall;
            MODE_PWM: step = (ctrl_q.src == SRC_EXT) ? ext_fall : pre_tick;
            default: step = 1'b0; // unused mode code counts nothing
        endcase
    end

    // counter, output flop and match pulse
    always_comb begin
        cnt_inc = cascade_inc(cnt_q);
        cnt_d = cnt_q;
        flop_d = flop_q;
        irq_d = 1'b0;
        duty_load = 1'b0;
        if (!running) begin
            cnt_d = CNT_RST;
            // a write while stopped loads the flop from init; a stopping write while running leaves it so the pin holds
            if (CTRL_WR_IN) begin
                flop_d = CTRL_IN.init;
            end
        end else if (step) begin
            if (ctrl_q.mode == MODE_PWM) begin
                if (cnt_q == CNT_MAX) begin
                    cnt_d = CNT_RST;
                    flop_d = !flop_q;
                    irq_d = 1'b1;
                    duty_load = 1'b1;
                end else begin
                    cnt_d = cnt_inc;
                    if (cnt_inc == duty_act) begin
                        flop_d = !flop_q;
                    end
                end
            end else if (cnt_inc == period_q) begin
                cnt_d = CNT_RST;
                irq_d = 1'b1;
            end else begin
                cnt_d = cnt_inc;
            end
        end
        pin_d = !flop_d;
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            cnt_q <= CNT_RST;
            flop_q <= 1'b0;
            pin_q <= 1'b1;
            irq_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            flop_q <= flop_d;
            pin_q <= pin_d;
            irq_q <= irq_d;
            ext_prev_q <= ext_prev_d;
        end
    end

    // every output is a register of this block or of the duty buffer
    assign COUNT_OUT = cnt_q;
    assign PERIOD_RD_OUT = period_q;
    assign DUTY_RD_OUT = duty_act;
    assign MATCH_IRQ_OUT = irq_q;
    assign PWM_PIN_OUT = pin_q;
    assign OUTPUT_FLOP_OUT = flop_q;
    assign RUNNING_OUT = running;

    property p_pin_inverse;
        @(posedge CLK_IN) disable iff (SRST_IN)
        PWM_PIN_OUT == !OUTPUT_FLOP_OUT;
    endproperty
    a_pin_inverse: assert property (p_pin_inverse)
        else $error("pin is not the inverse of the flop");

    property p_reset_flop;
        @(posedge CLK_IN)
        SRST_IN |=> !flop_q && pin_q;
    endproperty
    a_reset_flop: assert property (p_reset_flop)
        else $error("flop not cleared by reset");

    property p_period_match;
        @(posedge CLK_IN) disable iff (SRST_IN)
        running && step && (ctrl_q.mode != MODE_PWM) && (cnt_inc == period_q)
        |=> MATCH_IRQ_OUT && (COUNT_OUT == CNT_RST);
    endproperty
    a_period_match: assert property (p_period_match)
        else $error("period match did not clear and interrupt");

    property p_event_step;
        @(posedge CLK_IN) disable iff (SRST_IN)
        running && (ctrl_q.mode == MODE_EVENT) && ext_prev_q && !EXT_COUNT_IN
        && (cnt_inc != period_q) |=> (COUNT_OUT == cascade_inc($past(COUNT_OUT)));
    endproperty
    a_event_step: assert property (p_event_step)
        else $error("falling edge did not advance counter");

    property p_event_still;
        @(posedge CLK_IN) disable iff (SRST_IN)
        running && (ctrl_q.mode == MODE_EVENT) && !(ext_prev_q && !EXT_COUNT_IN)
        |=> $stable(COUNT_OUT) && !MATCH_IRQ_OUT;
    endproperty
    a_event_still: assert property (p_event_still)
        else $error("event counter moved without an edge");

    property p_duty_toggle;
        @(posedge CLK_IN) disable iff (SRST_IN)
        running && step && (ctrl_q.mode == MODE_PWM) && (cnt_q != CNT_MAX)
        && (cnt_inc == duty_act) |=> (flop_q != $past(flop_q)) && !MATCH_IRQ_OUT;
    endproperty
    a_duty_toggle: assert property (p_duty_toggle)
        else $error("duty match did not toggle flop");

    property p_overflow;
        @(posedge CLK_IN) disable iff (SRST_IN)
        running && step && (ctrl_q.mode == MODE_PWM) && (cnt_q == CNT_MAX)
        |=> MATCH_IRQ_OUT && (COUNT_OUT == CNT_RST) && (flop_q != $past(flop_q));
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow did not toggle, clear and interrupt");

    property p_stop_hold;
        @(posedge CLK_IN) disable iff (SRST_IN)
        running && CTRL_WR_IN && !CTRL_IN.run |=> !RUNNING_OUT && $stable(flop_q);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stopping write changed the output level");

    property p_timer_src;
        @(posedge CLK_IN) disable iff (SRST_IN)
        running && (ctrl_q.mode == MODE_TIMER) && !timer_src_ok(ctrl_q.src)
        |=> $stable(COUNT_OUT);
    endproperty
    a_timer_src: assert property (p_timer_src)
        else $error("interval mode counted on a foreign source");

    property p_stopped_clear;
        @(posedge CLK_IN) disable iff (SRST_IN)
        !running |=> (COUNT_OUT == CNT_RST) && !MATCH_IRQ_OUT;
    endproperty
    a_stopped_clear: assert property (p_stopped_clear)
        else $error("stopped counter not held at zero");

    property p_stopped_hold;
        @(posedge CLK_IN) disable iff (SRST_IN)
        !running && !CTRL_WR_IN |=> $stable(flop_q);
    endproperty
    a_stopped_hold: assert property (p_stopped_hold)
        else $error("stopped output level moved without a write");

    property p_start_load;
        @(posedge CLK_IN) disable iff (SRST_IN)
        !running && CTRL_WR_IN && CTRL_IN.run
        |=> RUNNING_OUT && (OUTPUT_FLOP_OUT == $past(CTRL_IN.init));
    endproperty
    a_start_load: assert property (p_start_load)
        else $error("starting write did not load the init level");

    property p_pwm_idle;
        @(posedge CLK_IN) disable iff (SRST_IN)
        running && (ctrl_q.mode == MODE_PWM) && !step
        |=> $stable(COUNT_OUT) && $stable(flop_q) && !MATCH_IRQ_OUT;
    endproperty
    a_pwm_idle: assert property (p_pwm_idle)
        else $error("pwm counter moved without a step");

endmodule

// ===== sim/cst_timer_test.sv
`timescale 1ns/1ps
module cst_timer_test import cst_pkg::*;;
    logic CLK_IN = 1'b0;
    logic SRST_IN = 1'b1;
    logic CTRL_WR_IN = 1'b0;
    cst_ctrl_t CTRL_IN = CTRL_RST;
    logic LOW_SPEED_SEL_IN = 1'b0;
    logic SLOW_STATE_IN = 1'b0;
    logic LF_TICK_IN = 1'b0;
    logic EXT_COUNT_IN = 1'b0;
    cst_bwr_t PERIOD_WR_IN = '0;
    cst_bwr_t DUTY_WR_IN = '0;
    logic [CNT_W-1:0] COUNT_OUT;
    logic [CNT_W-1:0] PERIOD_RD_OUT;
    logic [CNT_W-1:0] DUTY_RD_OUT;
    logic MATCH_IRQ_OUT;
    logic PWM_PIN_OUT;
    logic OUTPUT_FLOP_OUT;
    logic RUNNING_OUT;
    int bad_count = 0;
    int comparisons = 0;
    int n = 0;
    logic [3:0] lf_cnt = 4'h0;
    cst_src_t srcs [4] = '{SRC_DIV11, SRC_DIV7, SRC_DIV5, SRC_DIV3};
    int gaps [4] = '{4096, 256, 64, 16};

    cst_timer u_dut (
        .CLK_IN(CLK_IN),
        .SRST_IN(SRST_IN),
        .CTRL_WR_IN(CTRL_WR_IN),
        .CTRL_IN(CTRL_IN),
        .LOW_SPEED_SEL_IN(LOW_SPEED_SEL_IN),
        .SLOW_STATE_IN(SLOW_STATE_IN),
        .LF_TICK_IN(LF_TICK_IN),
        .EXT_COUNT_IN(EXT_COUNT_IN),
        .PERIOD_WR_IN(PERIOD_WR_IN),
        .DUTY_WR_IN(DUTY_WR_IN),
        .COUNT_OUT(COUNT_OUT),
        .PERIOD_RD_OUT(PERIOD_RD_OUT),
        .DUTY_RD_OUT(DUTY_RD_OUT),
        .MATCH_IRQ_OUT(MATCH_IRQ_OUT),
        .PWM_PIN_OUT(PWM_PIN_OUT),
        .OUTPUT_FLOP_OUT(OUTPUT_FLOP_OUT),
        .RUNNING_OUT(RUNNING_OUT)
    );

    // 125 MHz system clock
    initial begin
        forever #4 CLK_IN = ~CLK_IN;
    end

    // low clock stand-in: one pulse each 16 system clocks, slower than the 8-clock tap but faster than the 32-clock and slower taps
    always @(posedge CLK_IN) begin
        lf_cnt <= lf_cnt + 4'h1;
        LF_TICK_IN <= (lf_cnt == 4'hF);
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one control byte write, strobe held for exactly one edge
    task automatic ctrl(input logic init, input cst_mode_t m, input cst_src_t s,
                        input logic run);
        @(posedge CLK_IN);
        CTRL_WR_IN <= 1'b1;
        CTRL_IN <= '{init: init, mode: m, src: s, run: run};
        @(posedge CLK_IN);
        CTRL_WR_IN <= 1'b0;
        repeat (2) @(posedge CLK_IN);
        #1;
    endtask

    // whole 16-bit compare word, always low byte first then high byte
    task automatic wr_word(input logic duty, input logic [15:0] v);
        cst_bwr_t w;
        for (int b = 0; b < 2; b++) begin
            w = '{wr: 1'b1, hi: b[0], data: (b == 0) ? v[7:0] : v[15:8]};
            @(posedge CLK_IN);
            if (duty) DUTY_WR_IN <= w;
            else PERIOD_WR_IN <= w;
        end
        @(posedge CLK_IN);
        DUTY_WR_IN <= '0;
        PERIOD_WR_IN <= '0;
        repeat (2) @(posedge CLK_IN);
        #1;
    endtask

    // each level stands two cycles, the fastest legal input pace
    task automatic fall(input int k);
        repeat (k) begin
            repeat (2) @(posedge CLK_IN);
            EXT_COUNT_IN <= 1'b1;
            repeat (2) @(posedge CLK_IN);
            EXT_COUNT_IN <= 1'b0;
        end
    endtask

    task automatic settle;
        repeat (3) @(posedge CLK_IN);
        #1;
    endtask

    // bounded polls; n returns the cycles spent waiting
    task automatic wait_irq(input int lim);
        n = 0;
        do begin
            @(posedge CLK_IN);
            #1;
            n++;
        end while (MATCH_IRQ_OUT !== 1'b1 && n < lim);
    endtask

    task automatic wait_cnt(input logic [15:0] v, input int lim);
        n = 0;
        do begin
            @(posedge CLK_IN);
            #1;
            n++;
        end while (COUNT_OUT !== v && n < lim);
    endtask

    // watchdog sized above the longest run, one full 16-bit pwm period included
    initial begin
        #760000;
        bad_count++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge CLK_IN);
        SRST_IN <= 1'b0;
        settle();
        check(OUTPUT_FLOP_OUT, 1'b0);
        check(PWM_PIN_OUT, 1'b1);
        check(COUNT_OUT, 16'h0000);
        check({14'h0000, RUNNING_OUT, MATCH_IRQ_OUT}, 16'h0000);
        // interval timer on every fast tap, period 2
        wr_word(1'b0, 16'h0002);
        check(PERIOD_RD_OUT, 16'h0002);
        for (int i = 0; i < 4; i++) begin
            ctrl(1'b0, MODE_TIMER, srcs[i], 1'b1);
            check(RUNNING_OUT, 1'b1);
            wait_irq(gaps[i] + 20);
            wait_irq(gaps[i] + 20);
            check(16'(n), 16'(gaps[i]));
            ctrl(1'b0, MODE_TIMER, srcs[i], 1'b0);
            check(COUNT_OUT, 16'h0000);
        end
        // slow taps: low clock divided by 8 replaces the slowest fast tap
        @(posedge CLK_IN);
        LOW_SPEED_SEL_IN <= 1'b1;
        ctrl(1'b0, MODE_TIMER, SRC_DIV11, 1'b1);
        wait_irq(300);
        wait_irq(300);
        check(16'(n), 16'h0100);
        ctrl(1'b0, MODE_TIMER, SRC_DIV11, 1'b0);
        @(posedge CLK_IN);
        LOW_SPEED_SEL_IN <= 1'b0;
        SLOW_STATE_IN <= 1'b1;
        ctrl(1'b0, MODE_TIMER, SRC_DIV11, 1'b1);
        wait_irq(300);
        wait_irq(300);
        check(16'(n), 16'h0100);
        // a dead tap must give no match at all, not just a zero count
        ctrl(1'b0, MODE_TIMER, SRC_DIV3, 1'b1);
        wait_irq(100);
        check(16'(n), 16'h0064);
        check(COUNT_OUT, 16'h0000);
        ctrl(1'b0, MODE_TIMER, SRC_DIV3, 1'b0);
        @(posedge CLK_IN);
        SLOW_STATE_IN <= 1'b0;
        // event counter across the byte carry
        wr_word(1'b0, 16'h0102);
        ctrl(1'b0, MODE_EVENT, SRC_DIV3, 1'b1);
        fall(3);
        settle();
        check(COUNT_OUT, 16'h0003);
        fall(254);
        settle();
        check(COUNT_OUT, 16'h0101);
        fall(1);
        wait_irq(8);
        check(MATCH_IRQ_OUT, 1'b1);
        check(COUNT_OUT, 16'h0000);
        fall(1);
        settle();
        check(COUNT_OUT, 16'h0001);
        ctrl(1'b0, MODE_EVENT, SRC_DIV3, 1'b0);
        // pwm on the fast clock, duty reload only at overflow
        wr_word(1'b1, 16'h0010);
        check(DUTY_RD_OUT, 16'h0010);
        ctrl(1'b0, MODE_PWM, SRC_FC, 1'b1);
        wait_cnt(16'h0010, 40);
        check(OUTPUT_FLOP_OUT, 1'b1);
        check(PWM_PIN_OUT, 1'b0);
        wr_word(1'b1, 16'h0020);
        check(DUTY_RD_OUT, 16'h0010);
        wait_irq(66000);
        check(COUNT_OUT, 16'h0000);
        check(OUTPUT_FLOP_OUT, 1'b0);
        wait_cnt(16'h0002, 8);
        check(DUTY_RD_OUT, 16'h0020);
        wr_word(1'b1, 16'h0030);
        check(DUTY_RD_OUT, 16'h0020);
        wait_cnt(16'h001F, 40);
        check(OUTPUT_FLOP_OUT, 1'b0);
        wait_cnt(16'h0020, 4);
        check(OUTPUT_FLOP_OUT, 1'b1);
        // stopping holds the level even though the write carries init 0
        ctrl(1'b0, MODE_PWM, SRC_FC, 1'b0);
        check(OUTPUT_FLOP_OUT, 1'b1);
        check(PWM_PIN_OUT, 1'b0);
        ctrl(1'b0, MODE_PWM, SRC_FC, 1'b0);
        check(PWM_PIN_OUT, 1'b1);
        ctrl(1'b1, MODE_PWM, SRC_FC, 1'b0);
        check(OUTPUT_FLOP_OUT, 1'b1);
        check(PWM_PIN_OUT, 1'b0);
        // reset while stopped with the flop set clears the flop
        @(posedge CLK_IN);
        SRST_IN <= 1'b1;
        repeat (2) @(posedge CLK_IN);
        SRST_IN <= 1'b0;
        settle();
        check(OUTPUT_FLOP_OUT, 1'b0);
        check(PERIOD_RD_OUT, 16'h0000);
        // pwm on the fast clock halved and on the low clock
        ctrl(1'b0, MODE_PWM, SRC_FC_DIV2, 1'b1);
        wait_cnt(16'h0010, 40);
        wait_cnt(16'h0020, 40);
        check(16'(n), 16'h0020);
        ctrl(1'b0, MODE_PWM, SRC_FC_DIV2, 1'b0);
        ctrl(1'b0, MODE_PWM, SRC_FS, 1'b1);
        wait_cnt(16'h0002, 60);
        wait_cnt(16'h0006, 80);
        check(16'(n), 16'h0040);
        ctrl(1'b0, MODE_PWM, SRC_FS, 1'b0);
        // pwm clocked from the count input pin
        ctrl(1'b0, MODE_PWM, SRC_EXT, 1'b1);
        fall(2);
        settle();
        check(COUNT_OUT, 16'h0002);
        ctrl(1'b0, MODE_PWM, SRC_EXT, 1'b0);
        stop_test();
    end
endmodule
